// >>> hw/aisc_pkg.sv
package aisc_pkg;
    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    localparam int          REG_W         = 10;
    localparam logic [1:0]  ADDR_SETUP    = 2'h0;   // reg_addr_hi=0, reg_addr_lo=0
    localparam logic [1:0]  ADDR_HOSTIF   = 2'h1;   // reg_addr_lo=1
    // ----------------------------------------------------------------
    // conversion_setup fields
    // ----------------------------------------------------------------
    localparam int          CS_REF_SEL    = 0;
    localparam int          CS_SINGLE     = 1;
    localparam int          CS_PWR_DOWN   = 2;
    localparam int          CS_PICK_LO    = 3;
    localparam int          CS_PICK_HI    = 4;
    localparam int          CS_PAIR_LO    = 5;
    localparam int          CS_PAIR_HI    = 6;
    localparam int          CS_SCAN       = 7;
    localparam int          CS_CHECK_LO   = 8;
    localparam int          CS_CHECK_HI   = 9;
    localparam logic [9:0]  CS_RESET      = 10'h020;
    // ----------------------------------------------------------------
    // host_interface_setup fields
    // ----------------------------------------------------------------
    localparam int          HI_SOFT_RST   = 0;
    localparam int          HI_OVF_CLR    = 1;
    localparam int          HI_FILL_LO    = 2;
    localparam int          HI_FILL_HI    = 3;
    localparam int          HI_STB_TYPE   = 4;
    localparam int          HI_STB_POL    = 5;
    localparam int          HI_STB_MODE   = 6;
    localparam int          HI_NUM_FMT    = 7;
    localparam int          HI_OFFSET     = 8;
    localparam int          HI_RESERVED   = 9;
    localparam logic [9:0]  HI_RESET      = 10'h030;
    localparam logic [9:0]  HI_STORE_MASK = 10'h1FC;
    // ----------------------------------------------------------------
    // input selection codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  SEL_A_POS     = 3'h0;
    localparam logic [2:0]  SEL_A_NEG     = 3'h1;
    localparam logic [2:0]  SEL_B_POS     = 3'h2;
    localparam logic [2:0]  SEL_B_NEG     = 3'h3;
    localparam logic [2:0]  SEL_A_PAIR    = 3'h4;
    localparam logic [2:0]  SEL_B_PAIR    = 3'h5;
    localparam logic [2:0]  SEL_NONE      = 3'h7;
    // check voltage codes
    localparam logic [1:0]  CHK_NORMAL    = 2'h0;
    localparam logic [1:0]  CHK_TOP       = 2'h1;
    localparam logic [1:0]  CHK_MID       = 2'h2;
    localparam logic [1:0]  CHK_BOTTOM    = 2'h3;
endpackage : aisc_pkg

// >>> hw/aisc_scan_table.sv
`timescale 1ns/1ps
module aisc_scan_table (
    // configuration field and step
    input  wire logic [4:0] inputCfg,
    input  wire logic [1:0] step,
    // decoded entry
    output logic      [2:0] selCode,
    output logic      [1:0] lastStep,
    output logic            cfgValid
);
    // inputCfg = {scan, pair_hi, pair_lo, pick_hi, pick_lo}
    always_comb begin
        selCode  = aisc_pkg::SEL_NONE;
        lastStep = 2'h0;
        cfgValid = 1'b1;
        case (inputCfg)
            5'h00: selCode = aisc_pkg::SEL_A_POS;
            5'h01: selCode = aisc_pkg::SEL_A_NEG;
            5'h02: selCode = aisc_pkg::SEL_B_POS;
            5'h03: selCode = aisc_pkg::SEL_B_NEG;
            5'h04: selCode = aisc_pkg::SEL_A_PAIR;
            5'h05: selCode = aisc_pkg::SEL_B_PAIR;
            5'h11: begin
                lastStep = 2'h1;
                selCode  = step[0] ? aisc_pkg::SEL_A_NEG : aisc_pkg::SEL_A_POS;
            end
            5'h12: begin
                lastStep = 2'h2;
                selCode  = 3'(step);
            end
            5'h13: begin
                lastStep = 2'h3;
                selCode  = 3'(step);
            end
            5'h15: begin
                lastStep = 2'h1;
                selCode  = step[0] ? aisc_pkg::SEL_B_PAIR : aisc_pkg::SEL_A_POS;
            end
            5'h16: begin
                lastStep = 2'h2;
                selCode  = (step == 2'h2) ? aisc_pkg::SEL_B_PAIR : 3'(step);
            end
            5'h19: begin
                lastStep = 2'h1;
                selCode  = step[0] ? aisc_pkg::SEL_B_PAIR : aisc_pkg::SEL_A_PAIR;
            end
            default: cfgValid = 1'b0;
        endcase
    end
endmodule : aisc_scan_table

// >>> hw/aisc_input_scan.sv
`timescale 1ns/1ps
// Function
// - input configuration comes from bits 3..7 of conversion_setup.
// - channel pick bits 3,4 choose the single input or pair without scan.
// - bit 5 chooses single-ended versus differential use.
// - bits 6,7 enable and shape autoscan over several inputs.
// - no scan, no pairs: pick 0..3 selects A+, A-, B+, B- single-ended.
// - no scan, pair low set: pick 0 A pair, pick 1 B pair.
// - scan, pick 1: alternate A+ and A-.
// - scan, pick 2: A+, A-, B+ repeating.
// - scan, pick 3: A+, A-, B+, B- repeating.
// - scan, pair low, pick 1: alternate A+ and B pair.
// - scan, pair low, pick 2: A+, A-, B pair repeating.
// - scan, pair high, pick 1: alternate A pair and B pair.
// - bits 8,9 select normal, top, midpoint or bottom reference result.
// - host_interface_setup holds reset, clear, fill, strobe, format, offset, reserved.
// - both registers 10 bits; address 00 selects setup, 01 host interface.
// - reset puts pair low, strobe type and strobe polarity to one, all else zero: A differential pair.
module aisc_input_scan (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // register write and read port
    input  wire logic       regWrite,
    input  wire logic [1:0] regAddr,
    input  wire logic [9:0] regWrData,
    input  wire logic       regRead,
    // conversion events
    input  wire logic       convDone,
    input  wire logic       fifoOverflow,
    // register contents
    output logic      [9:0] setupRdData,
    output logic      [9:0] hostIfRdData,
    // decoded setup
    output logic      [2:0] inputSel,
    output logic            diffMode,
    output logic      [1:0] checkSel,
    output logic            scanActive,
    output logic            cfgReserved,
    output logic            extRefSel,
    output logic            singleConv,
    output logic            powerDown,
    // host interface controls
    output logic            softResetPulse,
    output logic            bufferClearPulse,
    output logic      [1:0] fillLevel,
    output logic            strobePulseType,
    output logic            strobeActiveHigh,
    output logic            strobeRwMode,
    output logic            numberFormat,
    output logic            offsetEnable
);
    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic [9:0] setup_reg;
    logic [9:0] hostIf_reg;
    logic       ovf_reg;
    logic [1:0] step_reg;
    logic [1:0] step_next;
    logic [2:0] tblSel;
    logic [1:0] tblLast;
    logic       tblValid;
    logic       wrSetup;
    logic       wrHostIf;
    logic       softRst;

    assign wrSetup  = regWrite && (regAddr == aisc_pkg::ADDR_SETUP);
    assign wrHostIf = regWrite && (regAddr == aisc_pkg::ADDR_HOSTIF);
    // other address codes are reserved and ignored
    assign softRst  = wrHostIf && regWrData[aisc_pkg::HI_SOFT_RST];

    // ----------------------------------------------------------------
    // conversion_setup register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_reg <= aisc_pkg::CS_RESET;
        end else if (softRst) begin
            setup_reg <= aisc_pkg::CS_RESET;
        end else if (wrSetup) begin
            setup_reg <= regWrData;
        end
    end

    // ----------------------------------------------------------------
    // host_interface_setup register
    // ----------------------------------------------------------------
    // reset and clear bits are strobes, not stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hostIf_reg <= aisc_pkg::HI_RESET;
        end else if (softRst) begin
            hostIf_reg <= aisc_pkg::HI_RESET;
        end else if (wrHostIf) begin
            hostIf_reg <= regWrData & aisc_pkg::HI_STORE_MASK;
        end
    end

    // overflow flag: set wins over clear-on-read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_reg <= 1'b0;
        end else if (fifoOverflow) begin
            ovf_reg <= 1'b1;
        end else if (softRst || (regRead && regAddr == aisc_pkg::ADDR_HOSTIF)) begin
            ovf_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            softResetPulse   <= 1'b0;
            bufferClearPulse <= 1'b0;
        end else begin
            softResetPulse   <= softRst;
            bufferClearPulse <= wrHostIf && regWrData[aisc_pkg::HI_OVF_CLR];
        end
    end

    // ----------------------------------------------------------------
    // scan sequencer
    // ----------------------------------------------------------------
    aisc_scan_table u_table (
        .inputCfg (setup_reg[aisc_pkg::CS_SCAN:aisc_pkg::CS_PICK_LO]),
        .step     (step_reg),
        .selCode  (tblSel),
        .lastStep (tblLast),
        .cfgValid (tblValid)
    );

    always_comb begin
        step_next = step_reg;
        if (convDone && setup_reg[aisc_pkg::CS_SCAN]) begin
            step_next = (step_reg >= tblLast) ? 2'h0 : 2'(step_reg + 2'h1);
        end
    end

    // a write restarts even an unchanged sequence, so the host can resync
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_reg <= 2'h0;
        end else if (wrSetup || softRst) begin
            step_reg <= 2'h0;
        end else begin
            step_reg <= step_next;
        end
    end

    // ----------------------------------------------------------------
    // decoded outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inputSel    <= aisc_pkg::SEL_A_PAIR;
            diffMode    <= 1'b1;
            cfgReserved <= 1'b0;
        end else begin
            inputSel    <= tblSel;
            diffMode    <= (tblSel == aisc_pkg::SEL_A_PAIR) ||
                           (tblSel == aisc_pkg::SEL_B_PAIR);
            cfgReserved <= !tblValid;
        end
    end

    assign scanActive       = setup_reg[aisc_pkg::CS_SCAN];
    assign checkSel         = setup_reg[aisc_pkg::CS_CHECK_HI:aisc_pkg::CS_CHECK_LO];
    assign extRefSel        = setup_reg[aisc_pkg::CS_REF_SEL];
    assign singleConv       = setup_reg[aisc_pkg::CS_SINGLE];
    assign powerDown        = setup_reg[aisc_pkg::CS_PWR_DOWN];
    assign fillLevel        = hostIf_reg[aisc_pkg::HI_FILL_HI:aisc_pkg::HI_FILL_LO];
    assign strobePulseType  = hostIf_reg[aisc_pkg::HI_STB_TYPE];
    assign strobeActiveHigh = hostIf_reg[aisc_pkg::HI_STB_POL];
    assign strobeRwMode     = hostIf_reg[aisc_pkg::HI_STB_MODE];
    assign numberFormat     = hostIf_reg[aisc_pkg::HI_NUM_FMT];
    assign offsetEnable     = hostIf_reg[aisc_pkg::HI_OFFSET];
    assign setupRdData      = setup_reg;
    // soft reset bit reads 0, bit 1 reads overflow, reserved reads 0
    assign hostIfRdData     = {1'b0, hostIf_reg[8:2], ovf_reg, 1'b0};
endmodule : aisc_input_scan

// >>> sim/aisc_input_scan_props.sv
`timescale 1ns/1ps
module aisc_input_scan_props (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // observed ports
    input wire logic       regWrite,
    input wire logic [1:0] regAddr,
    input wire logic [9:0] regWrData,
    input wire logic [9:0] setupRdData,
    input wire logic [9:0] hostIfRdData,
    input wire logic [2:0] inputSel,
    input wire logic       diffMode,
    input wire logic [1:0] checkSel,
    input wire logic       scanActive,
    input wire logic       cfgReserved,
    input wire logic       softResetPulse
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // every valid scan without pair-count high starts on input A positive
    sequence s_scan_wr;
        regWrite && regAddr == 2'h0 && regWrData[7] && !regWrData[6]
            && regWrData[4:3] != 2'h0 && regWrData[5:3] != 3'h7;
    endsequence
    sequence s_fixed_wr;
        regWrite && regAddr == 2'h0 && regWrData[7:5] == 3'h0;
    endsequence
    a_setup_write_seen: assert property (regWrite && regAddr == 2'h0 |=>
        setupRdData == $past(regWrData)) else $error("setup write not held");
    a_scan_restart_first: assert property (s_scan_wr ##1 !regWrite |->
        ##1 inputSel == aisc_pkg::SEL_A_POS) else $error("scan did not restart");
    a_fixed_input_decode: assert property (s_fixed_wr ##1 !regWrite |->
        ##1 inputSel == {1'b0, $past(regWrData[4:3], 2)}) else $error("bad fixed input");
    a_reset_setup_value: assert property ($rose(rst_n) |->
        setupRdData == aisc_pkg::CS_RESET && inputSel == aisc_pkg::SEL_A_PAIR)
        else $error("bad reset state");
    a_soft_reset_pulse: assert property (regWrite && regAddr == 2'h1 && regWrData[0] |=>
        softResetPulse && setupRdData == aisc_pkg::CS_RESET ##1 !softResetPulse)
        else $error("soft reset pulse wrong");
    a_reserved_addr_ignored: assert property (regWrite && regAddr[1] |=>
        $stable(setupRdData) && $stable(hostIfRdData[9:2])) else $error("reserved addr wrote");
    // tied to the written word, not to the register read-back
    a_check_sel_map: assert property (regWrite && regAddr == 2'h0 |=>
        checkSel == $past(regWrData[9:8])) else $error("check select mismatch");
    a_scan_flag_map: assert property (regWrite && regAddr == 2'h0 |=>
        scanActive == $past(regWrData[7])) else $error("scan flag mismatch");
    a_diff_pair_codes: assert property (diffMode == (inputSel == aisc_pkg::SEL_A_PAIR
        || inputSel == aisc_pkg::SEL_B_PAIR)) else $error("diff mode mismatch");
    a_reserved_no_input: assert property (cfgReserved |-> inputSel == aisc_pkg::SEL_NONE)
        else $error("reserved config selects input");
endmodule : aisc_input_scan_props

bind aisc_input_scan aisc_input_scan_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData),
    .setupRdData(setupRdData), .hostIfRdData(hostIfRdData), .inputSel(inputSel),
    .diffMode(diffMode), .checkSel(checkSel), .scanActive(scanActive),
    .cfgReserved(cfgReserved), .softResetPulse(softResetPulse));

// >>> sim/aisc_host_model.sv
`timescale 1ns/1ps
module aisc_host_model (
    // bus
    input  wire logic       sys_clk,
    output logic            regWrite,
    output logic      [1:0] regAddr,
    output logic      [9:0] regWrData,
    output logic            regRead
);
    initial begin
        regWrite  = 1'b0;
        regRead   = 1'b0;
        regAddr   = 2'h0;
        regWrData = 10'h000;
    end
    // one access per call; a gap cycle always follows
    task automatic access(input logic rd, input logic [1:0] a, input logic [9:0] d);
        @(negedge sys_clk);
        regWrite  = !rd;
        regRead   = rd;
        regAddr   = a;
        regWrData = d;
        @(negedge sys_clk);
        regWrite  = 1'b0;
        regRead   = 1'b0;
        regWrData = ~d; // released data lines carry no stale word
    endtask : access
endmodule : aisc_host_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        nMismatch++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module testbench;
    typedef struct {logic [4:0] cfg; int len; logic [0:3][2:0] seq;} aisc_row_s;
    logic sys_clk = 1'b0, rst_n = 1'b0, convDone = 1'b0, fifoOverflow = 1'b0;
    logic regWrite, regRead;
    logic [1:0] regAddr, checkSel, fillLevel;
    logic [9:0] regWrData, setupRdData, hostIfRdData, d;
    logic [2:0] inputSel, e;
    logic diffMode, scanActive, cfgReserved, softResetPulse, bufferClearPulse, numberFormat;
    logic offsetEnable, extRefSel, singleConv, powerDown;
    logic strobePulseType, strobeActiveHigh, strobeRwMode;
    int   nMismatch = 0, comparisons = 0;
    aisc_row_s tbl [15] = '{'{5'h00,1,'{3'h0,3'h0,3'h0,3'h0}}, '{5'h01,1,'{3'h1,3'h0,3'h0,3'h0}},
        '{5'h02,1,'{3'h2,3'h0,3'h0,3'h0}}, '{5'h03,1,'{3'h3,3'h0,3'h0,3'h0}},
        '{5'h04,1,'{3'h4,3'h0,3'h0,3'h0}}, '{5'h05,1,'{3'h5,3'h0,3'h0,3'h0}},
        '{5'h11,2,'{3'h0,3'h1,3'h0,3'h0}}, '{5'h12,3,'{3'h0,3'h1,3'h2,3'h0}},
        '{5'h13,4,'{3'h0,3'h1,3'h2,3'h3}}, '{5'h15,2,'{3'h0,3'h5,3'h0,3'h0}},
        '{5'h16,3,'{3'h0,3'h1,3'h5,3'h0}}, '{5'h19,2,'{3'h4,3'h5,3'h0,3'h0}},
        '{5'h06,1,'{3'h7,3'h0,3'h0,3'h0}}, '{5'h10,1,'{3'h7,3'h0,3'h0,3'h0}},
        '{5'h1F,1,'{3'h7,3'h0,3'h0,3'h0}}};
    always #5 sys_clk = ~sys_clk;
    aisc_host_model i_aisc_host_model (.sys_clk(sys_clk), .regWrite(regWrite),
        .regAddr(regAddr), .regWrData(regWrData), .regRead(regRead));
    aisc_input_scan i_aisc_input_scan (.sys_clk(sys_clk), .rst_n(rst_n), .regWrite(regWrite),
        .regAddr(regAddr), .regWrData(regWrData), .regRead(regRead), .convDone(convDone),
        .fifoOverflow(fifoOverflow), .setupRdData(setupRdData), .hostIfRdData(hostIfRdData),
        .inputSel(inputSel), .diffMode(diffMode), .checkSel(checkSel), .scanActive(scanActive),
        .cfgReserved(cfgReserved), .extRefSel(extRefSel), .singleConv(singleConv),
        .powerDown(powerDown),
        .softResetPulse(softResetPulse), .bufferClearPulse(bufferClearPulse),
        .fillLevel(fillLevel), .strobePulseType(strobePulseType),
        .strobeActiveHigh(strobeActiveHigh), .strobeRwMode(strobeRwMode),
        .numberFormat(numberFormat), .offsetEnable(offsetEnable));
    task automatic conv();
        @(negedge sys_clk) convDone = 1'b1;
        @(negedge sys_clk) convDone = 1'b0;
        @(negedge sys_clk);
    endtask : conv
    task automatic wrapUp();
        $display("comparisons %0d nMismatch %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrapUp
    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        `CHK("setup", aisc_pkg::CS_RESET, setupRdData)
        `CHK("hostif", aisc_pkg::HI_RESET, hostIfRdData)
        `CHK("input", aisc_pkg::SEL_A_PAIR, inputSel)
        `CHK("diff", 1'b1, diffMode)
        `CHK("strobe", 3'h3, {strobeRwMode, strobeActiveHigh, strobePulseType})
        foreach (tbl[r]) begin
            d = {r[1:0], tbl[r].cfg, r[2:0]};
            i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_SETUP, d);
            @(negedge sys_clk);
            `CHK("setup", d, setupRdData)
            `CHK("check", r[1:0], checkSel)
            `CHK("scan", tbl[r].cfg[4], scanActive)
            `CHK("low", r[2:0], {powerDown, singleConv, extRefSel})
            for (int k = 0; k < 2 * tbl[r].len; k++) begin
                e = tbl[r].seq[k % tbl[r].len];
                `CHK("input", e, inputSel)
                `CHK("diff", (e == 3'h4 || e == 3'h5), diffMode)
                `CHK("resv", (e == 3'h7), cfgReserved)
                conv();
            end
        end
        // same value again mid-scan must still restart
        i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_SETUP, 10'h098);
        conv();
        i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_SETUP, 10'h098);
        @(negedge sys_clk);
        `CHK("restart", aisc_pkg::SEL_A_POS, inputSel)
        i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_HOSTIF, 10'h3FC);
        `CHK("hostif", 10'h1FC, hostIfRdData)
        `CHK("fields", 4'hF, {fillLevel, numberFormat, offsetEnable})
        `CHK("strobes", 3'h7, {strobeRwMode, strobeActiveHigh, strobePulseType})
        @(negedge sys_clk) fifoOverflow = 1'b1;
        @(negedge sys_clk) fifoOverflow = 1'b0;
        `CHK("ovf", 1'b1, hostIfRdData[1])
        i_aisc_host_model.access(1'b1, aisc_pkg::ADDR_HOSTIF, 10'h000);
        `CHK("ovfclr", 1'b0, hostIfRdData[1])
        // overflow in the cycle of the clearing read must survive
        fork
            i_aisc_host_model.access(1'b1, aisc_pkg::ADDR_HOSTIF, 10'h000);
            begin
                @(negedge sys_clk) fifoOverflow = 1'b1;
                @(negedge sys_clk) fifoOverflow = 1'b0;
            end
        join
        `CHK("ovfwin", 1'b1, hostIfRdData[1])
        i_aisc_host_model.access(1'b1, aisc_pkg::ADDR_HOSTIF, 10'h000);
        `CHK("ovfclr2", 1'b0, hostIfRdData[1])
        i_aisc_host_model.access(1'b0, 2'h2, 10'h000);
        `CHK("resaddr", 10'h098, setupRdData)
        i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_HOSTIF, 10'h003);
        `CHK("pulses", 2'h3, {softResetPulse, bufferClearPulse})
        `CHK("softrst", aisc_pkg::CS_RESET, setupRdData)
        @(negedge sys_clk);
        `CHK("pulsend", 2'h0, {softResetPulse, bufferClearPulse})
        // asynchronous reset in mid-scan, then a fresh start
        i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_SETUP, 10'h398);
        i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_HOSTIF, 10'h0FC);
        conv();
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        `CHK("rsetup", aisc_pkg::CS_RESET, setupRdData)
        `CHK("rhostif", aisc_pkg::HI_RESET, hostIfRdData)
        `CHK("rinput", aisc_pkg::SEL_A_PAIR, inputSel)
        `CHK("rpulses", 2'h0, {softResetPulse, bufferClearPulse})
        i_aisc_host_model.access(1'b0, aisc_pkg::ADDR_SETUP, 10'h398);
        @(negedge sys_clk);
        `CHK("rrestart", aisc_pkg::SEL_A_POS, inputSel)
        `CHK("rcheck", 2'h3, checkSel)
        wrapUp();
    end
endmodule : testbench
